// *** dsrb_pkg.sv ***
// Purpose: Constants and state types for the drive status readout bank.
// Assumes: Parameter addresses are 16-bit and 32-bit values are read in one access.
// Notes: Every value is read-only; writes are answered with an error.
//
// Behaviour
// - I/O word bits 0..7 follow local or fieldbus mode input assignment
// - Input bit 6 enables only with local I/O command and pulse-direction input
// - I/O word bit 8 shows no-fault output, bit 9 shows active output
// - Actual q-axis current reads as signed 16 bits in 0.01 Apk
// - Commanded q-axis current reads as signed 16 bits in 0.01 Apk
// - Latest warning number is held in an unsigned 16-bit register
// - Warning number stays latched after warning clears until next fault reset
// - Latest warning reads zero when none was generated since last clearing
// - Actual motor speed reads as signed 16 bits in 1/min
// - Profile generator speed reads as signed 32 bits in 1/min
// - Reference generation speed reads as signed 32 bits in 1/min
package dsrb_pkg;

  // Parameter addresses as seen from the fieldbus
  localparam logic [15:0] ADDR_IO_STATUS_WORD = 16'h0802;
  localparam logic [15:0] ADDR_LATEST_WARNING = 16'h1c12;
  localparam logic [15:0] ADDR_Q_CURRENT_ACTUAL = 16'h1e02;
  localparam logic [15:0] ADDR_MOTOR_SPEED_ACTUAL = 16'h1e10;
  localparam logic [15:0] ADDR_Q_CURRENT_SETPOINT = 16'h1e20;
  localparam logic [15:0] ADDR_PROFILE_SPEED_ACTUAL = 16'h1f0c;
  localparam logic [15:0] ADDR_REF_GENERATOR_SPEED = 16'h1f0e;

  // Bit positions inside the I/O status word
  localparam int IO_BIT_HOME = 0;
  localparam int IO_BIT_FAULT_CLEAR = 1;
  localparam int IO_BIT_NEG_LIMIT = 1;
  localparam int IO_BIT_ENABLE = 2;
  localparam int IO_BIT_POS_LIMIT = 2;
  localparam int IO_BIT_HALT = 3;
  localparam int IO_BIT_RELEASE_B = 4;
  localparam int IO_BIT_RELEASE_A = 5;
  localparam int IO_BIT_SECOND_EN = 6;
  localparam int IO_BIT_NO_FAULT = 8;
  localparam int IO_BIT_ACTIVE = 9;

  // Selector codes for the command and position interfaces
  localparam logic [1:0] CMD_LOCAL_IO = 2'h1;
  localparam logic [1:0] POS_PULSE_DIR = 2'h1;

  // Values after reset
  localparam logic [15:0] RESET_WORD16 = 16'h0000;
  localparam logic [31:0] RESET_WORD32 = 32'h0000_0000;

  // Warning latch state
  typedef struct packed {
    logic [15:0] number;
  } dsrb_warn_state_t;

  // Bank state
  typedef struct packed {
    logic [15:0] io_word;
    logic [15:0] q_act;
    logic [15:0] q_ref;
    logic [15:0] n_act;
    logic [31:0] n_prof;
    logic [31:0] n_ref;
    logic second_en;
    logic ack;
    logic err;
    logic [31:0] rdata;
  } dsrb_state_t;

endpackage : dsrb_pkg

// *** dsrb_warn_latch.sv ***
// Purpose: Holds the number of the most recent warning.
// Assumes: A warning event is a one-cycle pulse with its number beside it.
// Notes: A new warning in the fault-reset cycle wins over the clear.
module dsrb_warn_latch (
  input wire logic core_clk_in,
  input wire logic srst_in,
  input wire logic warn_event_in,
  input wire logic [15:0] warn_num_in,
  input wire logic fault_reset_in,
  output logic [15:0] number_out
);

  dsrb_pkg::dsrb_warn_state_t st;
  dsrb_pkg::dsrb_warn_state_t next_st;

  // Latch on event, clear on fault reset; warning going inactive changes nothing
  always_comb begin
    next_st = st;
    if (warn_event_in) begin
      next_st.number = warn_num_in;
    end else if (fault_reset_in) begin
      next_st.number = dsrb_pkg::RESET_WORD16;
    end
  end

  // State register
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      st.number <= dsrb_pkg::RESET_WORD16;
    end else begin
      st <= next_st;
    end
  end

  assign number_out = st.number;

  a_warn_holds: assert property (@(posedge core_clk_in) disable iff (srst_in)
    !warn_event_in && !fault_reset_in |=> number_out == $past(number_out))
    else $error("Warning number changed without event or fault reset");

  a_warn_cleared: assert property (@(posedge core_clk_in) disable iff (srst_in)
    fault_reset_in && !warn_event_in ##1 (!warn_event_in)[*2] |-> number_out == 16'h0000)
    else $error("Warning number not zero after fault reset");

  a_warn_latched: assert property (@(posedge core_clk_in) disable iff (srst_in)
    warn_event_in |=> number_out == $past(warn_num_in))
    else $error("Warning number not latched");

endmodule : dsrb_warn_latch

// *** dsrb_bank.sv ***
// Purpose: Read-only status parameter bank of a servo drive, read by the fieldbus.
// Assumes: Live values are synchronous to core_clk_in and sampled every cycle.
// Notes: Reads answer one cycle after the request; writes are always refused.
module dsrb_bank (
  input wire logic core_clk_in,
  input wire logic srst_in,
  // Control mode: 0 local, 1 fieldbus
  input wire logic fieldbus_mode_in,
  input wire logic [1:0] command_interface_select_in,
  input wire logic [1:0] position_interface_select_in,
  // 24V inputs
  input wire logic home_switch_in,
  input wire logic fault_clear_input_in,
  input wire logic enable_input_in,
  input wire logic negative_limit_input_in,
  input wire logic positive_limit_input_in,
  input wire logic halt_input_in,
  input wire logic power_stage_release_b_in,
  input wire logic power_stage_release_a_in,
  input wire logic second_enable_input_in,
  // 24V outputs
  input wire logic no_fault_output_in,
  input wire logic active_output_in,
  // Live measurements
  input wire logic [15:0] q_current_actual_in,
  input wire logic [15:0] q_current_setpoint_in,
  input wire logic [15:0] motor_speed_actual_in,
  input wire logic [31:0] profile_speed_actual_in,
  input wire logic [31:0] reference_generator_speed_in,
  // Warning events
  input wire logic warn_event_in,
  input wire logic [15:0] warn_num_in,
  input wire logic fault_reset_in,
  // Fieldbus access port
  input wire logic acc_req_in,
  input wire logic acc_wr_in,
  input wire logic [15:0] acc_addr_in,
  output logic acc_ack_out,
  output logic acc_err_out,
  output logic [31:0] acc_rdata_out,
  // Enable derived from input bit 6
  output logic second_enable_active_out,
  output logic [15:0] latest_warning_number_out
);

  dsrb_pkg::dsrb_state_t st;
  dsrb_pkg::dsrb_state_t next_st;
  logic [15:0] warn_number;
  logic second_en_allowed;

  // Warning number latch
  dsrb_warn_latch dsrb_warn_latch_i (
    .core_clk_in(core_clk_in),
    .srst_in(srst_in),
    .warn_event_in(warn_event_in),
    .warn_num_in(warn_num_in),
    .fault_reset_in(fault_reset_in),
    .number_out(warn_number)
  );

  // Bit 6 counts as an enable only with local I/O commands and pulse-direction input
  assign second_en_allowed = !fieldbus_mode_in
    && (command_interface_select_in == dsrb_pkg::CMD_LOCAL_IO)
    && (position_interface_select_in == dsrb_pkg::POS_PULSE_DIR);

  // Sample live values and answer accesses from the sampled copies, so a read shows
  // the inputs of the cycle before the request; unused and reserved I/O bits read zero
  always_comb begin
    next_st = st;
    next_st.io_word = dsrb_pkg::RESET_WORD16;
    if (fieldbus_mode_in) begin
      next_st.io_word[dsrb_pkg::IO_BIT_HOME] = home_switch_in;
      next_st.io_word[dsrb_pkg::IO_BIT_NEG_LIMIT] = negative_limit_input_in;
      next_st.io_word[dsrb_pkg::IO_BIT_POS_LIMIT] = positive_limit_input_in;
    end else begin
      next_st.io_word[dsrb_pkg::IO_BIT_FAULT_CLEAR] = fault_clear_input_in;
      next_st.io_word[dsrb_pkg::IO_BIT_ENABLE] = enable_input_in;
      next_st.io_word[dsrb_pkg::IO_BIT_SECOND_EN] = second_enable_input_in;
    end
    next_st.io_word[dsrb_pkg::IO_BIT_HALT] = halt_input_in;
    next_st.io_word[dsrb_pkg::IO_BIT_RELEASE_B] = power_stage_release_b_in;
    next_st.io_word[dsrb_pkg::IO_BIT_RELEASE_A] = power_stage_release_a_in;
    next_st.io_word[dsrb_pkg::IO_BIT_NO_FAULT] = no_fault_output_in;
    next_st.io_word[dsrb_pkg::IO_BIT_ACTIVE] = active_output_in;
    next_st.q_act = q_current_actual_in;
    next_st.q_ref = q_current_setpoint_in;
    next_st.n_act = motor_speed_actual_in;
    next_st.n_prof = profile_speed_actual_in;
    next_st.n_ref = reference_generator_speed_in;
    next_st.second_en = second_en_allowed && second_enable_input_in;
    next_st.ack = acc_req_in;
    next_st.err = 1'b0;
    next_st.rdata = dsrb_pkg::RESET_WORD32;
    if (acc_req_in) begin
      if (acc_wr_in) begin
        // Nothing is stored; the bank has no writable state at all
        next_st.err = 1'b1;
      end else begin
        case (acc_addr_in)
          dsrb_pkg::ADDR_IO_STATUS_WORD: next_st.rdata = {16'h0000, st.io_word};
          dsrb_pkg::ADDR_LATEST_WARNING: next_st.rdata = {16'h0000, warn_number};
          dsrb_pkg::ADDR_Q_CURRENT_ACTUAL: next_st.rdata = {16'h0000, st.q_act};
          dsrb_pkg::ADDR_MOTOR_SPEED_ACTUAL: next_st.rdata = {16'h0000, st.n_act};
          dsrb_pkg::ADDR_Q_CURRENT_SETPOINT: next_st.rdata = {16'h0000, st.q_ref};
          dsrb_pkg::ADDR_PROFILE_SPEED_ACTUAL: next_st.rdata = st.n_prof;
          dsrb_pkg::ADDR_REF_GENERATOR_SPEED: next_st.rdata = st.n_ref;
          default: next_st.err = 1'b1; // Unmapped address
        endcase
      end
    end
  end

  // State register
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      st.io_word <= dsrb_pkg::RESET_WORD16;
      st.q_act <= dsrb_pkg::RESET_WORD16;
      st.q_ref <= dsrb_pkg::RESET_WORD16;
      st.n_act <= dsrb_pkg::RESET_WORD16;
      st.n_prof <= dsrb_pkg::RESET_WORD32;
      st.n_ref <= dsrb_pkg::RESET_WORD32;
      st.second_en <= 1'b0;
      st.ack <= 1'b0;
      st.err <= 1'b0;
      st.rdata <= dsrb_pkg::RESET_WORD32;
    end else begin
      st <= next_st;
    end
  end

  assign acc_ack_out = st.ack;
  assign acc_err_out = st.err;
  assign acc_rdata_out = st.rdata;
  assign second_enable_active_out = st.second_en;
  assign latest_warning_number_out = warn_number;

  a_io_local_map: assert property (@(posedge core_clk_in) disable iff (srst_in)
    !fieldbus_mode_in |=> st.io_word[0] == 1'b0 && st.io_word[7] == 1'b0
      && st.io_word[2] == $past(enable_input_in))
    else $error("Local mode input map wrong");

  a_io_bus_map: assert property (@(posedge core_clk_in) disable iff (srst_in)
    fieldbus_mode_in |=> st.io_word[6] == 1'b0 && st.io_word[0] == $past(home_switch_in)
      && st.io_word[1] == $past(negative_limit_input_in))
    else $error("Fieldbus mode input map wrong");

  a_second_en_gate: assert property (@(posedge core_clk_in) disable iff (srst_in)
    position_interface_select_in != 2'h1 |=> !second_enable_active_out)
    else $error("Second enable active without pulse-direction input");

  a_io_out_bits: assert property (@(posedge core_clk_in) disable iff (srst_in)
    1'b1 |=> st.io_word[9:8] == {$past(active_output_in), $past(no_fault_output_in)})
    else $error("Output bits not reflected");

  a_qact_read: assert property (@(posedge core_clk_in) disable iff (srst_in)
    acc_req_in && !acc_wr_in && acc_addr_in == 16'h1e02 ##0 1'b1 [*1]
      |=> acc_ack_out && !acc_err_out && acc_rdata_out == {16'h0000, $past(st.q_act)})
    else $error("Actual q current read wrong");

  a_prof_read: assert property (@(posedge core_clk_in) disable iff (srst_in)
    acc_req_in && !acc_wr_in && acc_addr_in == 16'h1f0c
      |=> acc_rdata_out == $past(st.n_prof))
    else $error("Profile speed read wrong");

  a_sample_chain: assert property (@(posedge core_clk_in) disable iff (srst_in)
    acc_req_in && !acc_wr_in && acc_addr_in == 16'h1f0e && !$past(srst_in)
      |=> acc_rdata_out == $past(reference_generator_speed_in, 2))
    else $error("Reference speed read wrong");

  a_write_refused: assert property (@(posedge core_clk_in) disable iff (srst_in)
    acc_req_in && acc_wr_in |=> acc_ack_out && acc_err_out && acc_rdata_out == 32'h0000_0000)
    else $error("Write not refused");

  a_no_spurious_ack: assert property (@(posedge core_clk_in) disable iff (srst_in)
    !acc_req_in |=> !acc_ack_out && !acc_err_out)
    else $error("Answer without request");

  // I/O word bits that do not depend on the control mode
  a_io_reserved_zero: assert property (@(posedge core_clk_in) disable iff (srst_in)
    1'b1
      |=> st.io_word[7] == 1'b0 && st.io_word[15:10] == 6'h00)
    else $error("Reserved I/O bits not zero");

  a_io_halt_bit: assert property (@(posedge core_clk_in) disable iff (srst_in)
    1'b1
      |=> st.io_word[3] == $past(halt_input_in))
    else $error("Halt bit not reflected");

  a_io_release_bits: assert property (@(posedge core_clk_in) disable iff (srst_in)
    1'b1 |=> st.io_word[5:4] == {$past(power_stage_release_a_in),
      $past(power_stage_release_b_in)})
    else $error("Release bits not reflected");

  // Mode-dependent bits; a mode change shows one cycle late, like the inputs
  a_io_local_clear: assert property (@(posedge core_clk_in) disable iff (srst_in)
    !fieldbus_mode_in
      |=> st.io_word[1] == $past(fault_clear_input_in))
    else $error("Fault clear bit wrong in local mode");

  a_io_local_second: assert property (@(posedge core_clk_in) disable iff (srst_in)
    !fieldbus_mode_in
      |=> st.io_word[6] == $past(second_enable_input_in))
    else $error("Second enable bit wrong in local mode");

  a_io_bus_poslim: assert property (@(posedge core_clk_in) disable iff (srst_in)
    fieldbus_mode_in
      |=> st.io_word[2] == $past(positive_limit_input_in))
    else $error("Positive limit bit wrong in fieldbus mode");

  // Second enable: the mode, command and input blocking conditions alone, then the passing case
  a_second_en_mode: assert property (@(posedge core_clk_in) disable iff (srst_in)
    fieldbus_mode_in
      |=> !second_enable_active_out)
    else $error("Second enable active in fieldbus mode");

  a_second_en_cmd: assert property (@(posedge core_clk_in) disable iff (srst_in)
    command_interface_select_in != 2'h1
      |=> !second_enable_active_out)
    else $error("Second enable active without local I/O commands");

  a_second_en_input: assert property (@(posedge core_clk_in) disable iff (srst_in)
    !second_enable_input_in
      |=> !second_enable_active_out)
    else $error("Second enable active with input low");

  a_second_en_pass: assert property (@(posedge core_clk_in) disable iff (srst_in)
    !fieldbus_mode_in && command_interface_select_in == 2'h1
      && position_interface_select_in == 2'h1
      |=> second_enable_active_out == $past(second_enable_input_in))
    else $error("Second enable not passed");

  // Live values land in the sampled copies one cycle after they are presented
  a_qact_sampled: assert property (@(posedge core_clk_in) disable iff (srst_in)
    1'b1
      |=> st.q_act == $past(q_current_actual_in))
    else $error("Actual q current not sampled");

  a_qref_sampled: assert property (@(posedge core_clk_in) disable iff (srst_in)
    1'b1
      |=> st.q_ref == $past(q_current_setpoint_in))
    else $error("Commanded q current not sampled");

  a_motor_speed_panel_code_sampled: assert property (@(posedge core_clk_in) disable iff (srst_in)
    1'b1
      |=> st.n_act == $past(motor_speed_actual_in))
    else $error("Motor speed not sampled");

  a_prof_sampled: assert property (@(posedge core_clk_in) disable iff (srst_in)
    1'b1
      |=> st.n_prof == $past(profile_speed_actual_in))
    else $error("Profile speed not sampled");

  a_nref_sampled: assert property (@(posedge core_clk_in) disable iff (srst_in)
    1'b1
      |=> st.n_ref == $past(reference_generator_speed_in))
    else $error("Reference speed not sampled");

  // Reads of the remaining parameters answer without error
  a_qref_read: assert property (@(posedge core_clk_in) disable iff (srst_in)
    acc_req_in && !acc_wr_in && acc_addr_in == 16'h1e20
      |=> acc_ack_out && !acc_err_out && acc_rdata_out == {16'h0000, $past(st.q_ref)})
    else $error("Commanded q current read wrong");

  a_motor_speed_panel_code_read: assert property (@(posedge core_clk_in) disable iff (srst_in)
    acc_req_in && !acc_wr_in && acc_addr_in == 16'h1e10
      |=> acc_ack_out && !acc_err_out && acc_rdata_out == {16'h0000, $past(st.n_act)})
    else $error("Motor speed read wrong");

  a_io_read: assert property (@(posedge core_clk_in) disable iff (srst_in)
    acc_req_in && !acc_wr_in && acc_addr_in == 16'h0802
      |=> acc_ack_out && !acc_err_out && acc_rdata_out == {16'h0000, $past(st.io_word)})
    else $error("I/O word read wrong");

  a_warn_read: assert property (@(posedge core_clk_in) disable iff (srst_in)
    acc_req_in && !acc_wr_in && acc_addr_in == 16'h1c12
      |=> acc_ack_out && !acc_err_out && acc_rdata_out == {16'h0000, $past(warn_number)})
    else $error("Warning number read wrong");

  a_ref_read_ok: assert property (@(posedge core_clk_in) disable iff (srst_in)
    acc_req_in && !acc_wr_in && acc_addr_in == 16'h1f0e
      |=> acc_ack_out && !acc_err_out)
    else $error("Reference speed read refused");

  a_prof_read_ok: assert property (@(posedge core_clk_in) disable iff (srst_in)
    acc_req_in && !acc_wr_in && acc_addr_in == 16'h1f0c
      |=> acc_ack_out && !acc_err_out)
    else $error("Profile speed read refused");

  // Refusals and the idle bus; data stays zero so a stale value cannot be mistaken
  a_hole_refused: assert property (@(posedge core_clk_in) disable iff (srst_in)
    acc_req_in && !acc_wr_in && !(acc_addr_in inside {16'h0802, 16'h1c12, 16'h1e02,
      16'h1e10, 16'h1e20, 16'h1f0c, 16'h1f0e})
      |=> acc_ack_out && acc_err_out && acc_rdata_out == 32'h0000_0000)
    else $error("Unmapped read not refused");

  a_rdata_idle: assert property (@(posedge core_clk_in) disable iff (srst_in)
    !acc_req_in
      |=> acc_rdata_out == 32'h0000_0000)
    else $error("Read data without request");

  a_ack_follows: assert property (@(posedge core_clk_in) disable iff (srst_in)
    acc_req_in
      |=> acc_ack_out)
    else $error("Request not answered");

  // Warning number as seen at the bank's own output
  a_warn_out_zero: assert property (@(posedge core_clk_in) disable iff (srst_in)
    fault_reset_in && !warn_event_in
      |=> latest_warning_number_out == 16'h0000)
    else $error("Warning output not cleared");

  a_warn_out_event: assert property (@(posedge core_clk_in) disable iff (srst_in)
    warn_event_in
      |=> latest_warning_number_out == $past(warn_num_in))
    else $error("Warning output not latched");

endmodule : dsrb_bank

// *** dsrb_master_model.sv ***
// Purpose: Fieldbus master that reads and writes bank parameters.
// Assumes: One request at a time, answered one cycle later.
// Notes: Released lines show inverted values, never stale ones.
module dsrb_master_model (
  input wire logic core_clk_in,
  output logic acc_req_out,
  output logic acc_wr_out,
  output logic [15:0] acc_addr_out,
  input wire logic acc_ack_in,
  input wire logic acc_err_in,
  input wire logic [31:0] acc_rdata_in
);
  timeunit 1ns;
  timeprecision 100ps;
  // Idle bus at time zero
  initial begin
    acc_req_out = 1'b0;
    acc_wr_out = 1'b0;
    acc_addr_out = 16'h0000;
  end
  // One access; answer taken at the falling edge after the answer edge
  task automatic access(input logic wr, input logic [15:0] a, output logic ack,
                        output logic err, output logic [31:0] d);
    @(negedge core_clk_in);
    acc_req_out = 1'b1;
    acc_wr_out = wr;
    acc_addr_out = a;
    @(negedge core_clk_in);
    ack = acc_ack_in;
    err = acc_err_in;
    d = acc_rdata_in;
    acc_req_out = 1'b0;
    acc_wr_out = ~wr;
    acc_addr_out = ~a;
  endtask : access
endmodule : dsrb_master_model

// *** dsrb_bank_test.sv ***
// Purpose: Self-checking bench for the status readout bank.
// Assumes: Inputs change at the falling clock edge.
// Notes: Register traffic goes through the master model.
module dsrb_bank_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic fb = 1'b0;
  logic ev = 1'b0;
  logic fr = 1'b0;
  logic [1:0] cmd = 2'h1;
  logic [1:0] pos = 2'h1;
  // home, fault clear, enable, limits, halt, releases, second enable
  logic [8:0] pin = 9'h000;
  logic [1:0] outs = 2'h0;
  logic [15:0] qa = 16'h0000;
  logic [15:0] qr = 16'h0000;
  logic [15:0] na = 16'h0000;
  logic [15:0] wn = 16'h0000;
  logic [31:0] np = 32'h0000_0000;
  logic [31:0] nr = 32'h0000_0000;
  logic req, wr, ack, err, sea;
  logic [15:0] addr, lw;
  logic [31:0] rd;
  int n_errors = 0;
  int comparisons = 0;
  always #12.5 clk = ~clk;
  // Device under test and its fieldbus master
  dsrb_bank dsrb_bank_i (.core_clk_in(clk), .srst_in(srst), .fieldbus_mode_in(fb),
    .command_interface_select_in(cmd), .position_interface_select_in(pos),
    .home_switch_in(pin[0]), .fault_clear_input_in(pin[1]), .enable_input_in(pin[2]),
    .negative_limit_input_in(pin[3]), .positive_limit_input_in(pin[4]),
    .halt_input_in(pin[5]), .power_stage_release_b_in(pin[6]),
    .power_stage_release_a_in(pin[7]), .second_enable_input_in(pin[8]),
    .no_fault_output_in(outs[0]), .active_output_in(outs[1]),
    .q_current_actual_in(qa), .q_current_setpoint_in(qr), .motor_speed_actual_in(na),
    .profile_speed_actual_in(np), .reference_generator_speed_in(nr),
    .warn_event_in(ev), .warn_num_in(wn), .fault_reset_in(fr),
    .acc_req_in(req), .acc_wr_in(wr), .acc_addr_in(addr), .acc_ack_out(ack),
    .acc_err_out(err), .acc_rdata_out(rd), .second_enable_active_out(sea),
    .latest_warning_number_out(lw));
  dsrb_master_model dsrb_master_model_i (.core_clk_in(clk), .acc_req_out(req),
    .acc_wr_out(wr), .acc_addr_out(addr), .acc_ack_in(ack), .acc_err_in(err),
    .acc_rdata_in(rd));
  task automatic check(input string what, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // Access and compare ack, err and data in one go
  task automatic expect_acc(input logic w, input logic [15:0] a, input logic [1:0] ae,
                            input logic [31:0] exp);
    logic k, e;
    logic [31:0] d;
    dsrb_master_model_i.access(w, a, k, e, d);
    check("ack err", {30'h0, k, e}, {30'h0, ae});
    check("read data", d, exp);
  endtask : expect_acc
  task automatic warning_test();
    expect_acc(1'b0, 16'h1c12, 2'h2, 32'h0);
    wn = 16'hbeef;
    ev = 1'b1;
    @(negedge clk);
    ev = 1'b0;
    wn = 16'h1234;
    repeat (6) @(negedge clk);
    check("latched number", {16'h0, lw}, 32'h0000_beef);
    expect_acc(1'b0, 16'h1c12, 2'h2, 32'h0000_beef);
    fr = 1'b1;
    @(negedge clk);
    fr = 1'b0;
    @(negedge clk);
    check("cleared number", {16'h0, lw}, 32'h0);
    // A warning in the fault-reset cycle outranks the clear
    {ev, fr, wn} = {2'b11, 16'h0007};
    @(negedge clk);
    {ev, fr} = 2'b00;
    @(negedge clk);
    check("event over clear", {16'h0, lw}, 32'h7);
  endtask : warning_test
  task automatic io_word_test();
    {fb, pin, outs} = {1'b0, 9'h1bb, 2'h1};
    repeat (3) @(negedge clk);
    expect_acc(1'b0, 16'h0802, 2'h2, 32'h0000_016a);
    {fb, outs} = {1'b1, 2'h2};
    repeat (3) @(negedge clk);
    expect_acc(1'b0, 16'h0802, 2'h2, 32'h0000_022f);
  endtask : io_word_test
  // Only local mode with both selectors at code 1 may pass the second enable
  task automatic enable_test();
    logic [5:0] k;
    for (int i = 0; i < 64; i++) begin
      k = i[5:0];
      {pin[8], fb, cmd, pos} = k;
      repeat (2) @(negedge clk);
      check("second enable", {31'h0, sea}, {31'h0, k == 6'h25});
    end
  endtask : enable_test
  task automatic value_test();
    {qa, qr, na} = {16'h8001, 16'hfff6, 16'h8000};
    {np, nr} = {32'h8000_0001, 32'hffff_fc18};
    repeat (3) @(negedge clk);
    expect_acc(1'b0, 16'h1e02, 2'h2, 32'h0000_8001);
    expect_acc(1'b0, 16'h1e20, 2'h2, 32'h0000_fff6);
    expect_acc(1'b0, 16'h1e10, 2'h2, 32'h0000_8000);
    expect_acc(1'b0, 16'h1f0c, 2'h2, 32'h8000_0001);
    expect_acc(1'b0, 16'h1f0e, 2'h2, 32'hffff_fc18);
  endtask : value_test
  // Writes to every parameter and reads of holes are refused
  task automatic refusal_test();
    logic [15:0] regs [7] = '{16'h0802, 16'h1c12, 16'h1e02, 16'h1e10, 16'h1e20,
                              16'h1f0c, 16'h1f0e};
    foreach (regs[i]) expect_acc(1'b1, regs[i], 2'h3, 32'h0);
    expect_acc(1'b0, 16'h0000, 2'h3, 32'h0);
    expect_acc(1'b0, 16'h1f10, 2'h3, 32'h0);
    expect_acc(1'b0, 16'h1e02, 2'h2, 32'h0000_8001);
    expect_acc(1'b0, 16'h1c12, 2'h2, 32'h0000_0007);
  endtask : refusal_test
  // Mid-run reset: a read taken at the first edge after release sees cleared copies
  task automatic reset_test();
    {nr, srst} = {32'h0000_0064, 1'b1};
    fork
      expect_acc(1'b0, 16'h1f0e, 2'h2, 32'h0);
      begin
        @(negedge clk);
        srst = 1'b0;
      end
    join
    check("number after reset", {16'h0, lw}, 32'h0);
    check("enable after reset", {31'h0, sea}, 32'h0);
    expect_acc(1'b0, 16'h1c12, 2'h2, 32'h0);
    expect_acc(1'b0, 16'h1f0e, 2'h2, 32'h0000_0064);
  endtask : reset_test
  task automatic report_and_stop();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop
  // Main sequence after an eight-cycle reset
  initial begin
    repeat (8) @(negedge clk);
    srst = 1'b0;
    @(negedge clk);
    warning_test();
    io_word_test();
    enable_test();
    value_test();
    refusal_test();
    reset_test();
    report_and_stop();
  end
  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (3000) @(posedge clk);
    n_errors++;
    report_and_stop();
  end
endmodule : dsrb_bank_test
